// *** src/operating_mode_controller.sv ***
// operating mode state machine of the system basis chip
// Summary of operation
// R1: power-up and soft reset enter init mode
// R2: stop mode keeps main regulator on
// R3: sleep mode switches main regulator off
// R4: wakes from sleep/fail-safe, failures enter restart
// R5: restart leaves for normal after delay
// R6: critical failures enter fail-safe, regulator off
// R7: fail-safe exits on wake or overtemperature clear
// R8: development mode stops the watchdog counter
// R9: development mode still reaches all modes
// R10: strap low during init selects development
// R11: all access uses 16-bit spi frames; code still leaves init on a frame of any length
// R12: controller writes mode field to change mode
// R13: restart clears the operating mode field
// R14: any spi command leaves init for normal
// R15: no trigger in long window: restart
// R16: wakes in init mode are discarded
// R17: normal-mode wake raises interrupt, mode unchanged
// R18: mode change applied after full frame checked
`timescale 1ns/1ps
module operating_mode_controller #(
  parameter int LONG_WINDOW_CYC = opmode_pkg::LONG_WINDOW_CYC,
  parameter int RESET_DELAY_CYC = opmode_pkg::RESET_DELAY_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic csN,
  input wire logic mosi,
  input wire logic softReset,
  input wire logic wdFailure,
  input wire logic wdTrigger,
  input wire logic mainUnderVoltage,
  input wire logic failSafeSelect,
  input wire logic overTemp,
  input wire logic busWake,
  input wire logic wakeInputs,
  input wire logic devStrapN,
  output logic mainRegulatorOn,
  output logic mcuResetN,
  output logic wakeIrq,
  output logic watchdogRun,
  output logic devMode,
  output logic [2:0] operatingModeField,
  output logic [2:0] modeState
);
  opmode_pkg::opmode_type state_r, state_nxt;
  logic [15:0] frameData;
  logic frameValid, frameOk;
  logic [2:0] pinSync_r [0:6];
  logic [6:0] pinLvl_r;
  logic [31:0] timer_r;
  logic devMode_r, strapSeen_r;
  logic [2:0] field_r;

  spi_frame_rx #(.FRAME_BITS(opmode_pkg::FRAME_BITS)) rx (
    .clk(clk),
    .rst(rst),
    .sck(sck),
    .csN(csN),
    .mosi(mosi),
    .frameData(frameData),
    .frameValid(frameValid),
    .frameOk(frameOk)
  ); // R11

  // pins from outside: three flops, change taken when last two agree
  wire [6:0] pinRaw = {devStrapN, wakeInputs, busWake, overTemp, mainUnderVoltage,
                       wdFailure, softReset};
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_sync
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          pinSync_r[gi] <= (gi == 6) ? 3'h7 : 3'h0;
          pinLvl_r[gi] <= (gi == 6) ? 1'b1 : 1'b0;
        end else begin
          pinSync_r[gi] <= {pinSync_r[gi][1:0], pinRaw[gi]};
          if (pinSync_r[gi][1] == pinSync_r[gi][2]) pinLvl_r[gi] <= pinSync_r[gi][2];
        end
      end
    end
  endgenerate

  wire softRst = pinLvl_r[0];
  wire failure = pinLvl_r[1] | pinLvl_r[2];
  wire hot = pinLvl_r[3];
  wire wake = pinLvl_r[4] | pinLvl_r[5];
  wire strapLow = !pinLvl_r[6];
  // only a checked full frame with the write bit set carries a mode request
  wire cmd = frameValid; // R14
  wire modeWrite = frameValid && frameOk && frameData[opmode_pkg::WRITE_BIT]; // R18 R12
  wire [2:0] reqMode = frameData[opmode_pkg::MODE_LSB +: 3];
  // watchdog expiry only counted while it runs; development mode freezes it
  wire wdRunning = (state_r == opmode_pkg::ST_INIT) && !devMode_r; // R8
  wire windowOut = wdRunning && timer_r >= 32'(LONG_WINDOW_CYC - 1); // R15
  wire delayDone = timer_r >= 32'(RESET_DELAY_CYC - 1);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      opmode_pkg::ST_INIT: begin
        // wakes are simply not looked at here
        if (windowOut) state_nxt = opmode_pkg::ST_RESTART; // R15 R16
        else if (cmd) state_nxt = opmode_pkg::ST_NORMAL; // R14
      end
      opmode_pkg::ST_NORMAL, opmode_pkg::ST_STOP: begin
        if (failure) state_nxt = failSafeSelect ? opmode_pkg::ST_FAILSAFE
                                                : opmode_pkg::ST_RESTART; // R4 R6
        else if (modeWrite) begin // R9
          unique case (reqMode)
            opmode_pkg::MODE_SLEEP: state_nxt = opmode_pkg::ST_SLEEP;
            opmode_pkg::MODE_STOP: state_nxt = opmode_pkg::ST_STOP;
            opmode_pkg::MODE_RESET: state_nxt = opmode_pkg::ST_INIT;
            opmode_pkg::MODE_NORMAL: state_nxt = opmode_pkg::ST_NORMAL;
            default: state_nxt = state_r;
          endcase
        end
      end
      opmode_pkg::ST_SLEEP: begin
        if (wake) state_nxt = opmode_pkg::ST_RESTART; // R4
      end
      opmode_pkg::ST_RESTART: begin
        if (failSafeSelect && failure) state_nxt = opmode_pkg::ST_FAILSAFE; // R6
        else if (!failure && delayDone) state_nxt = opmode_pkg::ST_NORMAL; // R5
      end
      opmode_pkg::ST_FAILSAFE: begin
        if (wake || !hot) state_nxt = opmode_pkg::ST_RESTART; // R7
      end
      default: state_nxt = opmode_pkg::ST_INIT;
    endcase
    if (softRst) state_nxt = opmode_pkg::ST_INIT; // R1
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= opmode_pkg::ST_INIT; // R1
      timer_r <= 32'h0;
    end else begin
      state_r <= state_nxt;
      // delay counter restarts on entry and while a failure persists
      // a trigger in init restarts the long window
      if (state_nxt != state_r || (state_r == opmode_pkg::ST_RESTART && failure) ||
          (state_r == opmode_pkg::ST_INIT && wdTrigger)) // R15
        timer_r <= 32'h0;
      else if (timer_r != 32'hFFFFFFFF) timer_r <= timer_r + 32'h1;
    end
  end

  // strap followed through the first init stay, frozen once init is left;
  // a single first-edge sample would only see the synchroniser's reset value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      devMode_r <= 1'b0;
      strapSeen_r <= 1'b0;
    end else if (state_r == opmode_pkg::ST_INIT && !strapSeen_r) begin
      devMode_r <= strapLow; // R10
    end else if (state_r != opmode_pkg::ST_INIT) begin
      strapSeen_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      field_r <= opmode_pkg::MODE_NORMAL;
      wakeIrq <= 1'b0;
    end else begin
      // cleared on entry, so a read during restart already shows normal
      if (state_nxt == opmode_pkg::ST_RESTART) field_r <= opmode_pkg::MODE_NORMAL; // R13
      else if (state_nxt == opmode_pkg::ST_SLEEP) field_r <= opmode_pkg::MODE_SLEEP;
      else if (state_nxt == opmode_pkg::ST_STOP) field_r <= opmode_pkg::MODE_STOP;
      else if (state_nxt == opmode_pkg::ST_NORMAL) field_r <= opmode_pkg::MODE_NORMAL;
      wakeIrq <= (state_r == opmode_pkg::ST_NORMAL) && wake; // R17
    end
  end

  assign mainRegulatorOn = (state_r != opmode_pkg::ST_SLEEP) &&
                           (state_r != opmode_pkg::ST_FAILSAFE); // R2 R3 R6
  assign mcuResetN = (state_r != opmode_pkg::ST_RESTART) &&
                     (state_r != opmode_pkg::ST_FAILSAFE); // R4
  assign watchdogRun = wdRunning;
  assign devMode = devMode_r;
  assign operatingModeField = field_r;
  assign modeState = state_r;

  sleep_reg_off_a: assert property (@(posedge clk) disable iff (rst)
    state_r == opmode_pkg::ST_SLEEP |-> !mainRegulatorOn) else $error("regulator on in sleep"); // R3
  stop_reg_on_a: assert property (@(posedge clk) disable iff (rst)
    state_r == opmode_pkg::ST_STOP |-> mainRegulatorOn) else $error("regulator off in stop"); // R2
  failsafe_reg_a: assert property (@(posedge clk) disable iff (rst)
    state_r == opmode_pkg::ST_FAILSAFE |-> !mainRegulatorOn && !mcuResetN)
    else $error("failsafe outputs wrong"); // R6
  restart_reset_a: assert property (@(posedge clk) disable iff (rst)
    state_r == opmode_pkg::ST_RESTART |-> !mcuResetN) else $error("mcu not held in restart"); // R4
  restart_clear_a: assert property (@(posedge clk) disable iff (rst)
    state_r == opmode_pkg::ST_RESTART |-> field_r == opmode_pkg::MODE_NORMAL)
    else $error("mode field not cleared"); // R13
  init_cmd_a: assert property (@(posedge clk) disable iff (rst)
    state_r == opmode_pkg::ST_INIT && frameValid && !windowOut && !softRst
    |=> state_r == opmode_pkg::ST_NORMAL) else $error("init ignored command"); // R14
  sleep_wake_a: assert property (@(posedge clk) disable iff (rst)
    state_r == opmode_pkg::ST_SLEEP && wake && !softRst |=> state_r == opmode_pkg::ST_RESTART)
    else $error("sleep wake lost"); // R4
  normal_wake_a: assert property (@(posedge clk) disable iff (rst)
    state_r == opmode_pkg::ST_NORMAL && wake |=> wakeIrq) else $error("no wake irq"); // R17
  dev_wd_a: assert property (@(posedge clk) disable iff (rst)
    devMode_r |-> !watchdogRun) else $error("watchdog runs in dev mode"); // R8
  bad_frame_a: assert property (@(posedge clk) disable iff (rst)
    state_r == opmode_pkg::ST_NORMAL && !failure && !softRst && !(frameValid && frameOk)
    |=> state_r == opmode_pkg::ST_NORMAL) else $error("mode change without frame"); // R18
endmodule

// *** src/opmode_pkg.sv ***
// constants and types for the operating mode controller
package opmode_pkg;
  localparam int FRAME_BITS = 16;
  localparam int CLK_HZ = 10000000;
  // reset delay time in microseconds, long open window in milliseconds
  localparam int RESET_DELAY_US = 10;
  localparam int LONG_WINDOW_MS = 200;
  localparam int RESET_DELAY_CYC = (RESET_DELAY_US * (CLK_HZ / 1000000) > 0) ?
                                   RESET_DELAY_US * (CLK_HZ / 1000000) : 1;
  localparam int LONG_WINDOW_CYC = LONG_WINDOW_MS * (CLK_HZ / 1000);
  // operating mode field encodings
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_SLEEP = 3'h1;
  localparam logic [2:0] MODE_STOP = 3'h2;
  localparam logic [2:0] MODE_RESET = 3'h3;
  // mode field position inside a write frame
  localparam int MODE_LSB = 13;
  localparam int WRITE_BIT = 7;
  typedef enum logic [2:0] {
    ST_INIT = 3'b000,
    ST_NORMAL = 3'b001,
    ST_STOP = 3'b010,
    ST_SLEEP = 3'b011,
    ST_RESTART = 3'b100,
    ST_FAILSAFE = 3'b101
  } opmode_type;
endpackage

// *** src/spi_frame_rx.sv ***
// 16-bit spi slave receiver, mode 0, pulses a checked frame
`timescale 1ns/1ps
module spi_frame_rx #(
  parameter int FRAME_BITS = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic csN,
  input wire logic mosi,
  output logic [FRAME_BITS-1:0] frameData,
  output logic frameValid,
  output logic frameOk
);
  logic [2:0] sckSync_r, csSync_r, mosiSync_r;
  logic [FRAME_BITS-1:0] shift_r;
  logic [5:0] count_r;
  logic sckLvl_r, csLvl_r;
  wire sckStable = sckSync_r[1] == sckSync_r[2];
  wire csStable = csSync_r[1] == csSync_r[2];
  wire sckRise = sckStable && sckSync_r[2] && !sckLvl_r;
  wire csRise = csStable && csSync_r[2] && !csLvl_r;
  wire active = !csLvl_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sckSync_r <= 3'h0;
      csSync_r <= 3'h7;
      mosiSync_r <= 3'h0;
    end else begin
      sckSync_r <= {sckSync_r[1:0], sck};
      csSync_r <= {csSync_r[1:0], csN};
      mosiSync_r <= {mosiSync_r[1:0], mosi};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sckLvl_r <= 1'b0;
      csLvl_r <= 1'b1;
      shift_r <= '0;
      count_r <= 6'h0;
      frameValid <= 1'b0;
      frameOk <= 1'b0;
      frameData <= '0;
    end else begin
      frameValid <= 1'b0;
      if (sckStable) sckLvl_r <= sckSync_r[2];
      if (csStable) csLvl_r <= csSync_r[2];
      if (csStable && !csSync_r[2] && csLvl_r) count_r <= 6'h0;
      else if (sckRise && active) begin
        shift_r <= {shift_r[FRAME_BITS-2:0], mosiSync_r[2]};
        if (count_r != 6'h3F) count_r <= count_r + 6'h01;
      end
      // frame ends at chip select release; length checked there
      if (csRise) begin
        frameValid <= 1'b1;
        frameOk <= count_r == 6'(FRAME_BITS);
        frameData <= shift_r;
      end
    end
  end
endmodule

// *** testbench/spi_master_model.sv ***
// spi master model standing in for the microcontroller
`timescale 1ns/1ps
module spi_master_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [4:0] bitCount,
  input wire logic [15:0] word,
  output logic sck,
  output logic csN,
  output logic mosi,
  output logic busy
);
  initial begin
    sck = 1'b0;
    csN = 1'b1;
    mosi = 1'b0;
    busy = 1'b0;
  end
  // msb first, data changes while sck low, 5 clk per phase
  always begin
    @(posedge clk);
    if (go && !busy) begin
      busy <= 1'b1;
      csN <= 1'b0;
      for (int i = 0; i < bitCount; i++) begin
        mosi <= word[15 - i];
        repeat (5) @(posedge clk);
        sck <= 1'b1;
        repeat (5) @(posedge clk);
        sck <= 1'b0;
      end
      repeat (5) @(posedge clk);
      csN <= 1'b1;
      // released line must not keep showing the last bit
      mosi <= ~mosi;
      busy <= 1'b0;
    end
  end
endmodule

// *** testbench/tb.sv ***
// self-checking bench for the operating mode controller
`timescale 1ns/1ps
module tb;
  // short counts keep the run brief
  localparam int LW = 400;
  localparam int RD = 20;
  localparam logic [2:0] S_INIT = 3'(opmode_pkg::ST_INIT);
  localparam logic [2:0] S_NORM = 3'(opmode_pkg::ST_NORMAL);
  localparam logic [2:0] S_RST = 3'(opmode_pkg::ST_RESTART);
  localparam logic [2:0] S_FS = 3'(opmode_pkg::ST_FAILSAFE);
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic softReset = 1'b0, wdFailure = 1'b0, wdTrigger = 1'b0, mainUnderVoltage = 1'b0;
  logic failSafeSelect = 1'b0, overTemp = 1'b0, busWake = 1'b0, wakeInputs = 1'b0;
  logic devStrapN = 1'b1, go = 1'b0;
  logic [4:0] bitCount = 5'h10;
  logic [15:0] word = 16'h0000;
  logic sck, csN, mosi, busy, regOn, mcuResetN, wakeIrq, wdRun, devMode;
  logic [2:0] field, modeState;
  int err_total = 0;
  int samples_checked = 0;
  int n;
  always #50 clk = ~clk;
  spi_master_model mst_u (.clk(clk), .go(go), .bitCount(bitCount), .word(word), .sck(sck),
    .csN(csN), .mosi(mosi), .busy(busy));
  operating_mode_controller #(.LONG_WINDOW_CYC(LW), .RESET_DELAY_CYC(RD)) dut_u (
    .clk(clk), .rst(rst), .sck(sck), .csN(csN), .mosi(mosi), .softReset(softReset),
    .wdFailure(wdFailure), .wdTrigger(wdTrigger), .mainUnderVoltage(mainUnderVoltage),
    .failSafeSelect(failSafeSelect), .overTemp(overTemp), .busWake(busWake),
    .wakeInputs(wakeInputs), .devStrapN(devStrapN), .mainRegulatorOn(regOn),
    .mcuResetN(mcuResetN), .wakeIrq(wakeIrq), .watchdogRun(wdRun), .devMode(devMode),
    .operatingModeField(field), .modeState(modeState));
  function automatic logic [2:0] exp_state(input logic [2:0] m);
    case (m)
      opmode_pkg::MODE_STOP: return 3'(opmode_pkg::ST_STOP);
      opmode_pkg::MODE_SLEEP: return 3'(opmode_pkg::ST_SLEEP);
      default: return S_NORM;
    endcase
  endfunction
  function automatic logic exp_reg(input logic [2:0] st);
    return !(st == 3'(opmode_pkg::ST_SLEEP) || st == S_FS);
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic send(input logic [15:0] w, input logic [4:0] bits);
    word <= w;
    bitCount <= bits;
    go <= 1'b1;
    repeat (2) @(posedge clk);
    go <= 1'b0;
    n = 0;
    while (busy === 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    // csN sync and state update take a few clk
    repeat (8) @(posedge clk);
  endtask
  task automatic set_mode(input logic [2:0] m);
    send({m, 5'h00, 1'b1, 7'h00}, 5'h10);
    check(8'(modeState), 8'(exp_state(m)));
    check(8'({regOn, field}), 8'({exp_reg(exp_state(m)), m}));
  endtask
  task automatic run_modes;
    set_mode(opmode_pkg::MODE_STOP);
    set_mode(opmode_pkg::MODE_NORMAL);
    set_mode(opmode_pkg::MODE_SLEEP);
  endtask
  task automatic wait_state(input logic [2:0] st, input int lim);
    n = 0;
    while (modeState !== st && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic do_reset(input logic strapN);
    devStrapN <= strapN;
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    close_out();
  end
  initial begin
    n = $urandom(2);
    do_reset(1'b1);
    check(8'(modeState), 8'(S_INIT));
    check(8'({regOn, mcuResetN, wdRun, devMode}), 8'h0E);
    busWake <= 1'b1;
    repeat (6) @(posedge clk);
    busWake <= 1'b0;
    repeat (6) @(posedge clk);
    check(8'({wakeIrq, modeState}), 8'(S_INIT));
    send({opmode_pkg::MODE_STOP, 5'h00, 1'b1, 7'h00}, 5'h0C);
    check(8'({field, modeState}), 8'(S_NORM));
    send({opmode_pkg::MODE_STOP, 5'h00, 1'b0, 7'h00}, 5'h10);
    check(8'(modeState), 8'(S_NORM));
    send({3'h4 | 3'($urandom % 4), 5'h00, 1'b1, 7'h00}, 5'h10);
    check(8'(modeState), 8'(S_NORM));
    n = $urandom % 2;
    busWake <= (n == 0);
    wakeInputs <= (n != 0);
    repeat (6) @(posedge clk);
    check(8'({wakeIrq, modeState}), 8'({1'b1, S_NORM}));
    busWake <= 1'b0;
    wakeInputs <= 1'b0;
    run_modes();
    wakeInputs <= 1'b1;
    wait_state(S_RST, 20);
    check(8'({mcuResetN, field, modeState}), 8'(S_RST));
    wakeInputs <= 1'b0;
    wait_state(S_NORM, RD + 10);
    check(8'({modeState, 1'(n >= RD - 2)}), 8'({S_NORM, 1'b1}));
    wdFailure <= 1'b1;
    wait_state(S_RST, 10);
    repeat (RD + 10) @(posedge clk);
    check(8'({mcuResetN, modeState}), 8'(S_RST));
    wdFailure <= 1'b0;
    wait_state(S_NORM, RD + 10);
    check(8'(modeState), 8'(S_NORM));
    // hot die holds fail-safe; exit once by wake, once by cooling
    for (int k = 0; k < 2; k++) begin
      failSafeSelect <= 1'b1;
      overTemp <= 1'b1;
      mainUnderVoltage <= 1'b1;
      wait_state(S_FS, 10);
      mainUnderVoltage <= 1'b0;
      repeat (RD + 10) @(posedge clk);
      check(8'({regOn, mcuResetN, modeState}), 8'(S_FS));
      if (k == 0)
        busWake <= 1'b1;
      else
        overTemp <= 1'b0;
      wait_state(S_RST, 10);
      check(8'(modeState), 8'(S_RST));
      busWake <= 1'b0;
      overTemp <= 1'b0;
      wait_state(S_NORM, RD + 10);
    end
    send({opmode_pkg::MODE_RESET, 5'h00, 1'b1, 7'h00}, 5'h10);
    check(8'(modeState), 8'(S_INIT));
    wait_state(S_RST, LW + 20);
    check(8'({modeState, 1'(n >= LW - 20)}), 8'({S_RST, 1'b1}));
    wait_state(S_NORM, RD + 10);
    send({opmode_pkg::MODE_RESET, 5'h00, 1'b1, 7'h00}, 5'h10);
    repeat (LW - 40) @(posedge clk);
    wdTrigger <= 1'b1;
    @(posedge clk);
    wdTrigger <= 1'b0;
    repeat (60) @(posedge clk);
    check(8'(modeState), 8'(S_INIT));
    wait_state(S_RST, LW + 20);
    check(8'({modeState, 1'(n >= LW - 80)}), 8'({S_RST, 1'b1}));
    wait_state(S_NORM, RD + 10);
    softReset <= 1'b1;
    repeat (6) @(posedge clk);
    softReset <= 1'b0;
    check(8'(modeState), 8'(S_INIT));
    do_reset(1'b0);
    repeat (LW + 20) @(posedge clk);
    check(8'({wdRun, devMode, modeState}), 8'h08);
    set_mode(opmode_pkg::MODE_NORMAL);
    run_modes();
    close_out();
  end
endmodule
